// *** cache_clock_config_ctrl.sv ***
// Purpose: Cache and clock-doubling configuration behind the index/data I/O ports
// Assumes: clk is the double_rate_input_clock domain at 25 MHz; rstn is the hardware reset
// Notes:   Cache array itself is outside; this block steers it and the clock doubler
`timescale 1ns/100ps
`include "cache_clock_params.svh"
module cache_clock_config_ctrl (
	input  wire logic                     clk,
	input  wire logic                     rstn,
	input  wire cache_clock_pkg::io_req_t io_req,
	input  wire logic                     cr0_we,
	input  wire logic [31:0]              cr0_wdata,
	input  wire logic                     soft_reboot,
	input  wire logic                     hold_ack_pin,
	input  wire logic                     lookup_valid,
	input  wire logic [31:0]              lookup_addr,
	output logic [7:0]                    io_rdata,
	output logic                          io_rvalid,
	output logic                          clock_doubled,
	output logic                          cache_disabled,
	output logic                          cache_flush,
	output logic                          cacheable,
	output logic                          cacheable_valid,
	output logic                          two_way_assoc
);
	// ==========================================================
	// Helpers
	function automatic logic in_low_window(input logic [31:0] a);
		in_low_window = (a[31:`MB_LSB] != `ABOVE_CLEAR) && (a[`WIN_MSB:`WIN_LSB] == `WIN_CLEAR);
	endfunction

	function automatic logic is_port(input cache_clock_pkg::io_req_t r, input logic [15:0] p);
		is_port = r.sel && (r.addr == p);
	endfunction

	// ==========================================================
	// State
	cache_clock_pkg::config_t cfg_q, cfg_d;
	logic [7:0] idx_q, idx_d;
	logic [7:0] rdata_q, rdata_d;
	logic       rvalid_q, rvalid_d;
	logic       cd_q, cd_d;
	logic       flush_q, flush_d;
	logic       cach_q, cach_d;
	logic       cvalid_q, cvalid_d;
	logic       two_way_q;
	logic       hold_level;
	logic       hold_rise;

	sync_edge u_hold_sync (
		.clk   (clk),
		.rstn  (rstn),
		.d_in  (hold_ack_pin),
		.level (hold_level),
		.rise  (hold_rise)
	);

	// ==========================================================
	// Register access and control
	always_comb begin
		idx_d    = idx_q;
		cfg_d    = cfg_q;
		rdata_d  = rdata_q;
		rvalid_d = 1'b0;
		cd_d     = cd_q;
		// Index port selects, data port reaches the selected register
		if (is_port(io_req, `IO_INDEX_PORT)) begin
			if (io_req.we) begin
				idx_d = io_req.wdata;
			end else begin
				rdata_d  = idx_q;
				rvalid_d = 1'b1;
			end
		end else if (is_port(io_req, `IO_DATA_PORT)) begin
			if (io_req.we) begin
				// Whole byte stored, so 23h leaves only the two noncache bits and flush-on-hold
				if (idx_q == `IDX_CONFIG_ZERO) begin
					cfg_d = io_req.wdata;
				end
			end else begin
				rdata_d  = (idx_q == `IDX_CONFIG_ZERO) ? cfg_q : `UNMAPPED_READ;
				rvalid_d = 1'b1;
			end
		end
		if (cr0_we) begin
			cd_d = cr0_wdata[`CR0_CD_BIT];
		end
	end

	// ==========================================================
	// Cache steering
	always_comb begin
		// Lookups answer one cycle later; a disabled cache answers noncacheable
		cvalid_d = lookup_valid;
		cach_d   = lookup_valid && !cd_q &&
			!(cfg_q.low_region_noncache_bit && in_low_window(lookup_addr));
		// Hold entry is taken from the synchronised pin, so flush lags the pin by three edges
		flush_d  = hold_rise && cfg_q.flush_on_hold_bit;
	end

	// Only the hardware reset touches these; soft_reboot is deliberately not wired
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			idx_q     <= `IDX_RESET;
			cfg_q     <= `CONFIG_ZERO_RESET;
			rdata_q   <= `IDX_RESET;
			rvalid_q  <= 1'b0;
			cd_q      <= `CACHE_DIS_RESET;
			flush_q   <= 1'b0;
			cach_q    <= 1'b0;
			cvalid_q  <= 1'b0;
			two_way_q <= 1'b1;
		end else begin
			idx_q     <= idx_d;
			cfg_q     <= cfg_d;
			rdata_q   <= rdata_d;
			rvalid_q  <= rvalid_d;
			cd_q      <= cd_d;
			flush_q   <= flush_d;
			cach_q    <= cach_d;
			cvalid_q  <= cvalid_d;
			two_way_q <= 1'b1;
		end
	end

	// ==========================================================
	// Outputs
	// Doubling follows the stored bit; the board must not slow clk while it is set
	assign clock_doubled   = cfg_q.clock_double;
	assign cache_disabled  = cd_q;
	assign cache_flush     = flush_q;
	assign cacheable       = cach_q;
	assign cacheable_valid = cvalid_q;
	assign two_way_assoc   = two_way_q;
	assign io_rdata        = rdata_q;
	assign io_rvalid       = rvalid_q;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	logic seen_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			seen_q <= 1'b0;
		end else begin
			seen_q <= 1'b1;
		end
	end

	logic cfg_wr;
	assign cfg_wr = is_port(io_req, `IO_DATA_PORT) && io_req.we && (idx_q == `IDX_CONFIG_ZERO);

	property p_double_follows_bit;
		cfg_wr |=> (clock_doubled == $past(io_req.wdata[`CLK_DOUBLE_BIT]));
	endproperty
	a_double_follows_bit: assert property (p_double_follows_bit)
		else $error("clock doubling does not follow bit 6");

	property p_two_way;
		seen_q |-> two_way_assoc;
	endproperty
	a_two_way: assert property (p_two_way)
		else $error("cache left two-way organisation");

	property p_reset_state;
		!seen_q |-> (cache_disabled && !clock_doubled && !cache_flush);
	endproperty
	a_reset_state: assert property (p_reset_state)
		else $error("cache or doubling on after hardware reset");

	property p_soft_reboot_keeps;
		(soft_reboot && !io_req.sel && !cr0_we) |=> ($stable(cfg_q) && $stable(cache_disabled));
	endproperty
	a_soft_reboot_keeps: assert property (p_soft_reboot_keeps)
		else $error("soft reboot changed cache or doubling setting");

	property p_cr0_disable;
		cr0_we |=> (cache_disabled == $past(cr0_wdata[`CR0_CD_BIT]));
	endproperty
	a_cr0_disable: assert property (p_cr0_disable)
		else $error("cache disable does not follow bit 30");

	property p_disabled_no_cache;
		(lookup_valid && cache_disabled) |=> (cacheable_valid && !cacheable);
	endproperty
	a_disabled_no_cache: assert property (p_disabled_no_cache)
		else $error("lookup cacheable while cache disabled");

	property p_value_23;
		(cfg_wr && io_req.wdata == `NC_FOH_VALUE) |=>
			(cfg_q.low_region_noncache_bit && cfg_q.second_region_noncache_bit &&
			 cfg_q.flush_on_hold_bit && !cfg_q.clock_double && !clock_doubled);
	endproperty
	a_value_23: assert property (p_value_23)
		else $error("writing 23h did not give noncache and flush-on-hold bits only");

	property p_low_window;
		(lookup_valid && cfg_q.low_region_noncache_bit && in_low_window(lookup_addr))
			|=> (cacheable_valid && !cacheable);
	endproperty
	a_low_window: assert property (p_low_window)
		else $error("first 64K above a 1M boundary was cached");

	property p_flush_on_hold;
		($rose(hold_level) && cfg_q.flush_on_hold_bit) |=> cache_flush ##1 !cache_flush;
	endproperty
	a_flush_on_hold: assert property (p_flush_on_hold)
		else $error("hold entry did not give one flush pulse");

	property p_no_flush_without_hold;
		cache_flush |-> $past(hold_rise);
	endproperty
	a_no_flush_without_hold: assert property (p_no_flush_without_hold)
		else $error("flush without hold entry");

	property p_index_data_read;
		(is_port(io_req, `IO_DATA_PORT) && !io_req.we && idx_q == `IDX_CONFIG_ZERO)
			|=> (io_rvalid && io_rdata == $past(cfg_q));
	endproperty
	a_index_data_read: assert property (p_index_data_read)
		else $error("data port read did not return selected register");

	c_double_on: cover property (cfg_wr && io_req.wdata[`CLK_DOUBLE_BIT] ##1 clock_doubled);
	c_flush: cover property (cache_flush);
	c_window_miss: cover property (cacheable_valid && !cacheable && !cache_disabled);
	c_reenable: cover property (cache_disabled ##1 !cache_disabled);
endmodule

// *** cache_clock_params.svh ***
// Purpose: Constants for the cache and clock-doubling configuration block
// Assumes: Included by its bare name; definitions only
// Notes:   Field layouts of the configuration byte live in cache_clock_pkg
//
// How it works
// - Bit 6 of config_control_zero set selects doubled clocking; clear returns normal.
// - Cache is always two-way set associative; no bit selects direct mapped.
// - Hardware reset turns off the cache and doubled clocking until software re-enables.
// - A soft reboot without hardware reset leaves cache and doubling settings alone.
// - Control register zero bit 30 set disables the cache; clear enables it.
// - Writing 23h sets both noncache bits and flush-on-hold, all others clear.
// - Low noncache bit set: first 64K above each 1M boundary from 1M upward is not cached; the first 64K of memory stays cached.
// - Flush-on-hold bit set: whole cache is invalidated on entering bus hold.
`ifndef CACHE_CLOCK_PARAMS_SVH
`define CACHE_CLOCK_PARAMS_SVH

// ==========================================================
// I/O port map
`define IO_INDEX_PORT     16'h0022
`define IO_DATA_PORT      16'h0023
`define IDX_CONFIG_ZERO   8'hc0
`define IDX_RESET         8'h00
`define UNMAPPED_READ     8'hff

// ==========================================================
// Reset values, and the 23h noncache and flush-on-hold write value
`define CONFIG_ZERO_RESET 8'h00
`define CACHE_DIS_RESET   1'b1
`define NC_FOH_VALUE      8'h23

// ==========================================================
// Architectural control register zero
`define CR0_CD_BIT        30

// ==========================================================
// Configuration byte field that selects doubled clocking
`define CLK_DOUBLE_BIT    6

// ==========================================================
// Noncacheable window: 64K above each 1M boundary from 1M upward
`define MB_LSB            20
`define WIN_MSB           19
`define WIN_LSB           16
`define WIN_CLEAR         4'h0
`define ABOVE_CLEAR       12'h000

`endif

// *** cache_clock_pkg.sv ***
// Purpose: Types shared by the cache and clock-doubling configuration block
// Assumes: Nothing
// Notes:   Field order of config_t is the bit order of the configuration byte
package cache_clock_pkg;

	// ==========================================================
	// Configuration byte, bit 7 down to bit 0
	typedef struct packed {
		logic       spare7;
		logic       clock_double;
		logic       flush_on_hold_bit;
		logic [2:0] spare4_2;
		logic       second_region_noncache_bit;
		logic       low_region_noncache_bit;
	} config_t;

	// ==========================================================
	// One I/O cycle from the core
	typedef struct packed {
		logic        sel;
		logic        we;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} io_req_t;

endpackage

// *** sync_edge.sv ***
// Purpose: Two-flop synchroniser with rising-edge detect
// Assumes: d_in is asynchronous to clk
// Notes:   First stage is read only by the second stage
`timescale 1ns/100ps
module sync_edge (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic d_in,
	output logic      level,
	output logic      rise
);
	logic s1_q, s2_q, s3_q;
	logic s1_d, s2_d, s3_d;

	always_comb begin
		s1_d = d_in;
		s2_d = s1_q;
		s3_d = s2_q;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
		end
	end

	assign level = s2_q;
	assign rise  = s2_q & ~s3_q;
endmodule

// *** cache_clock_config_ctrl_tb_top.sv ***
// Purpose: Self-checking bench for the cache and clock-doubling configuration block
// Assumes: Inputs change by non-blocking assignment at the rising clock edge
// Notes:   Levels are checked 1 ns after an edge so that edge updates have landed
`timescale 1ns/100ps
`include "cache_clock_params.svh"
module cache_clock_config_ctrl_tb_top;
	logic                     clk;
	logic                     rstn;
	cache_clock_pkg::io_req_t io_req;
	logic                     cr0_we;
	logic [31:0]              cr0_wdata;
	logic                     soft_reboot;
	logic                     hold_ack_pin;
	logic                     lookup_valid;
	logic [31:0]              lookup_addr;
	logic [7:0]               io_rdata;
	logic                     io_rvalid;
	logic                     clock_doubled;
	logic                     cache_disabled;
	logic                     cache_flush;
	logic                     cacheable;
	logic                     cacheable_valid;
	logic                     two_way_assoc;
	int                       errors;
	int                       checks;

	cache_clock_config_ctrl dut_u (
		.clk             (clk),
		.rstn            (rstn),
		.io_req          (io_req),
		.cr0_we          (cr0_we),
		.cr0_wdata       (cr0_wdata),
		.soft_reboot     (soft_reboot),
		.hold_ack_pin    (hold_ack_pin),
		.lookup_valid    (lookup_valid),
		.lookup_addr     (lookup_addr),
		.io_rdata        (io_rdata),
		.io_rvalid       (io_rvalid),
		.clock_doubled   (clock_doubled),
		.cache_disabled  (cache_disabled),
		.cache_flush     (cache_flush),
		.cacheable       (cacheable),
		.cacheable_valid (cacheable_valid),
		.two_way_assoc   (two_way_assoc)
	);

	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One-cycle strobe; the extra edge lets registered levels follow the write
	task automatic io_wr(input logic [15:0] addr, input logic [7:0] data);
		@(posedge clk) io_req <= {1'b1, 1'b1, addr, data};
		@(posedge clk) io_req <= {1'b0, 1'b0, addr, data};
		@(posedge clk);
		#1;
	endtask

	task automatic cfg_wr(input logic [7:0] data);
		io_wr(`IO_INDEX_PORT, `IDX_CONFIG_ZERO);
		io_wr(`IO_DATA_PORT, data);
	endtask

	// Read answer stands for one cycle right after the taking edge
	task automatic io_rd(input logic [15:0] addr, input logic [7:0] exp);
		@(posedge clk) io_req <= {1'b1, 1'b0, addr, 8'h00};
		@(posedge clk) io_req <= {1'b0, 1'b0, addr, 8'h00};
		#1;
		chk({7'h00, io_rvalid}, 8'h01);
		chk(io_rdata, exp);
	endtask

	task automatic cr0_wr(input logic [31:0] data);
		@(posedge clk) begin
			cr0_we    <= 1'b1;
			cr0_wdata <= data;
		end
		@(posedge clk) cr0_we <= 1'b0;
		@(posedge clk);
		#1;
	endtask

	task automatic lookup(input logic [31:0] addr, input logic exp);
		@(posedge clk) begin
			lookup_valid <= 1'b1;
			lookup_addr  <= addr;
		end
		@(posedge clk) lookup_valid <= 1'b0;
		#1;
		chk({7'h00, cacheable_valid}, 8'h01);
		chk({7'h00, cacheable}, {7'h00, exp});
	endtask

	// Pin sampled at the next edge; flush expected after the third edge only
	task automatic hold_pulse(input logic exp);
		@(posedge clk) hold_ack_pin <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk({7'h00, cache_flush}, 8'h00);
		@(posedge clk);
		#1;
		chk({7'h00, cache_flush}, {7'h00, exp});
		@(posedge clk);
		#1;
		chk({7'h00, cache_flush}, 8'h00);
		@(posedge clk) hold_ack_pin <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset_state;
		chk({6'h00, clock_doubled, cache_disabled}, 8'h01);
		chk({7'h00, two_way_assoc}, 8'h01);
		cfg_wr(8'hff);
		chk({6'h00, clock_doubled, cache_disabled}, 8'h03);
		chk({7'h00, two_way_assoc}, 8'h01);
		io_wr(`IO_INDEX_PORT, `IDX_CONFIG_ZERO);
		$display("done reset_state");
	endtask

	task automatic t_config_access;
		cfg_wr(`NC_FOH_VALUE);
		io_rd(`IO_DATA_PORT, 8'h23);
		io_rd(`IO_INDEX_PORT, `IDX_CONFIG_ZERO);
		io_wr(`IO_INDEX_PORT, 8'hc1);
		io_wr(`IO_DATA_PORT, 8'h00);
		io_rd(`IO_DATA_PORT, `UNMAPPED_READ);
		io_wr(`IO_INDEX_PORT, `IDX_CONFIG_ZERO);
		io_rd(`IO_DATA_PORT, 8'h23);
		chk({7'h00, clock_doubled}, 8'h00);
		$display("done config_access");
	endtask

	task automatic t_doubling;
		io_wr(`IO_DATA_PORT, 8'h63);
		chk({7'h00, clock_doubled}, 8'h01);
		io_wr(`IO_DATA_PORT, 8'h23);
		chk({7'h00, clock_doubled}, 8'h00);
		$display("done doubling");
	endtask

	task automatic t_cr0_and_lookup;
		cr0_wr(32'h4000_0000);
		chk({7'h00, cache_disabled}, 8'h01);
		lookup(32'h0000_5000, 1'b0);
		cfg_wr(`NC_FOH_VALUE);
		cr0_wr(32'hbfff_ffff);
		chk({7'h00, cache_disabled}, 8'h00);
		lookup(32'h0010_5000, 1'b0);
		lookup(32'h0020_ffff, 1'b0);
		lookup(32'h0011_0000, 1'b1);
		lookup(32'h0000_5000, 1'b1);
		io_wr(`IO_DATA_PORT, 8'h22);
		lookup(32'h0010_5000, 1'b1);
		$display("done cr0_and_lookup");
	endtask

	task automatic t_hold_flush;
		io_wr(`IO_DATA_PORT, 8'h02);
		hold_pulse(1'b0);
		io_wr(`IO_DATA_PORT, 8'h23);
		hold_pulse(1'b1);
		$display("done hold_flush");
	endtask

	task automatic t_reboots;
		io_wr(`IO_DATA_PORT, 8'h63);
		@(posedge clk) soft_reboot <= 1'b1;
		repeat (3) @(posedge clk);
		soft_reboot <= 1'b0;
		@(posedge clk);
		#1;
		chk({6'h00, clock_doubled, cache_disabled}, 8'h02);
		io_rd(`IO_DATA_PORT, 8'h63);
		@(posedge clk) rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		#1;
		chk({6'h00, clock_doubled, cache_disabled}, 8'h01);
		io_wr(`IO_INDEX_PORT, `IDX_CONFIG_ZERO);
		io_rd(`IO_DATA_PORT, `CONFIG_ZERO_RESET);
		$display("done reboots");
	endtask

	// ==========================================================
	// Verdict, clock, stimulus and watchdog
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Input clock is never scaled or stopped, doubled mode or not
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		errors       = 0;
		checks       = 0;
		rstn         = 1'b0;
		io_req       = '0;
		cr0_we       = 1'b0;
		cr0_wdata    = 32'h0000_0000;
		soft_reboot  = 1'b0;
		hold_ack_pin = 1'b0;
		lookup_valid = 1'b0;
		lookup_addr  = 32'h0000_0000;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		#1;
		t_reset_state();
		t_config_access();
		t_doubling();
		t_cr0_and_lookup();
		t_hold_flush();
		t_reboots();
		conclude();
	end

	// Whole run is about 120 cycles; this limit is far beyond it
	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		conclude();
	end
endmodule
